// ===== core/txenc_consts.svh
`ifndef TXENC_CONSTS_SVH
`define TXENC_CONSTS_SVH

// Host control codes with the encoder enabled
`define TXE_CTRL_DATA     2'h0
`define TXE_CTRL_FILL     2'h1
`define TXE_CTRL_SPECIAL  2'h2
`define TXE_CTRL_SYNC     2'h3

// Character values
`define TXE_K285_BYTE     8'hBC
`define TXE_K285_NEG      10'h17C
`define TXE_K285_POS      10'h283
`define TXE_VIOL_NEG      10'h1F9
`define TXE_VIOL_POS      10'h206
`define TXE_STATIC_ONE    10'h3FF

// Word sync counter
`define TXE_SYNC_IDLE     4'h0
`define TXE_SYNC_FIRST    4'h1
`define TXE_SYNC_STEP     4'h1
`define TXE_SYNC_LAST     4'hF

// Clock multiplier and speed range
`define TXE_MULT_FULL     5'h0A
`define TXE_MULT_HALF     5'h14
`define TXE_SPD_LOW       2'h0
`define TXE_SPD_MID       2'h1
`define TXE_SPD_HIGH      2'h2

// Special character tables
`define TXE_SPECIAL_COUNT 12
`define TXE_EXT_LAST      8'h0B
`define TXE_LFSR_SPC_NIB  4'h0

// Encoder fields
`define TXE_K28_X         5'h1C
`define TXE_K28_6B        6'h0F
`define TXE_A7_4B         4'h7
`define TXE_D7_X          5'h07
`define TXE_Y7            3'h7
`define TXE_Y3            3'h3
`define TXE_BAL6          3
`define TXE_BAL4          2

// Pattern generator
`define TXE_LFSR_W        9
`define TXE_LFSR_SEED     9'h1FF
`define TXE_LFSR_TAP      4

// Reset values of the configuration latches
`define TXE_RST_ENC_EN    1'h1
`define TXE_RST_SELFTEST  1'h0
`define TXE_RST_RATE      1'h0
`define TXE_RST_LOOPBACK  1'h0
`define TXE_RST_RXREF     1'h0

`endif

// ===== core/txenc_pkg.sv
`include "txenc_consts.svh"

package txenc_pkg;

  typedef struct packed {
    logic       viol;
    logic       isK;
    logic [7:0] code;
  } txenc_char_type;

  typedef struct packed {
    logic encoderEnableLatch;
    logic txSelftestLatch;
    logic refRateSelect;
    logic localLoopbackEnable;
    logic rxRefClockMode;
  } txenc_cfg_type;

  typedef enum logic [1:0] {BIST_OFF, BIST_SYNC, BIST_RUN} txenc_bist_type;

  localparam txenc_char_type TXENC_FILL_CHAR = '{viol: 1'h0, isK: 1'h1,
                                                 code: `TXE_K285_BYTE};

  // Special byte values, in the order of the extended index
  localparam logic [7:0] TXENC_SPECIAL [`TXE_SPECIAL_COUNT] = '{
    8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC,
    8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};

  // Extended table by index, the same whole table by value, else violation
  function automatic txenc_char_type txenc_map_special(input logic [7:0] v);
    txenc_map_special = '{viol: 1'h1, isK: 1'h1, code: v};
    if (v <= `TXE_EXT_LAST) begin
      txenc_map_special.viol = 1'h0;
      txenc_map_special.code = TXENC_SPECIAL[v[3:0]];
    end else begin
      for (int i = 0; i < `TXE_SPECIAL_COUNT; i++) begin
        if (v == TXENC_SPECIAL[i]) begin
          txenc_map_special.viol = 1'h0;
        end
      end
    end
  endfunction

endpackage

// ===== core/txenc_encoder.sv
`timescale 1ns/100ps
`include "txenc_consts.svh"

module txenc_encoder (
  input  wire txenc_pkg::txenc_char_type charIn,
  input  wire logic                      rdPosIn,
  output logic [9:0]                     codeOut,
  output logic                           rdPosOut
);
  import txenc_pkg::*;

  // Negative disparity forms, first code bit in the msb
  localparam logic [5:0] TBL6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] TBL4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  logic [4:0] x;
  logic [2:0] y;
  logic [5:0] c6;
  logic [3:0] c4;
  logic       rdMid;
  logic       isK28;
  logic       kFlip;
  logic       alt7;

  always_comb begin
    x     = charIn.code[4:0];
    y     = charIn.code[7:5];
    isK28 = charIn.isK && (x == `TXE_K28_X);
    c6    = isK28 ? `TXE_K28_6B : TBL6[x];
    if (rdPosIn && (($countones(c6) != `TXE_BAL6) || (x == `TXE_D7_X))) begin
      c6 = ~c6;
    end
    rdMid = ($countones(c6) == `TXE_BAL6) ? rdPosIn : !rdPosIn;
    kFlip = isK28 && (y inside {3'h1, 3'h2, 3'h5, 3'h6});
    alt7  = (y == `TXE_Y7) && (charIn.isK ||
            (!rdMid && (x inside {5'h11, 5'h12, 5'h14})) ||
            (rdMid && (x inside {5'h0B, 5'h0D, 5'h0E})));
    c4 = alt7 ? `TXE_A7_4B : TBL4[y];
    if (kFlip) begin
      c4 = ~c4;
    end
    if (rdMid && (($countones(c4) != `TXE_BAL4) || (y == `TXE_Y3) ||
                  kFlip)) begin
      c4 = ~c4;
    end
    rdPosOut = ($countones(c4) == `TXE_BAL4) ? rdMid : !rdMid;
    codeOut  = {<<{c6, c4}};
    if (charIn.viol) begin
      codeOut  = rdPosIn ? `TXE_VIOL_POS : `TXE_VIOL_NEG;
      rdPosOut = rdPosIn;
    end
  end

endmodule // txenc_encoder

// ===== core/txenc_lfsr.sv
`timescale 1ns/100ps
`include "txenc_consts.svh"

module txenc_lfsr (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 restart,
  input  wire logic                 advance,
  output txenc_pkg::txenc_char_type patternChar,
  output logic                      passLast
);
  import txenc_pkg::*;

  logic [`TXE_LFSR_W-1:0] state_q;
  logic [`TXE_LFSR_W-1:0] state_d;

  always_comb begin
    state_d  = {state_q[`TXE_LFSR_W-2:0],
                state_q[`TXE_LFSR_W-1] ^ state_q[`TXE_LFSR_TAP]};
    passLast = (state_d == `TXE_LFSR_SEED);
    patternChar = '{viol: 1'h0, isK: 1'h0, code: state_q[7:0]};
    if (state_q[`TXE_LFSR_W-1] && (state_q[7:4] == `TXE_LFSR_SPC_NIB)) begin
      patternChar = txenc_map_special(state_q[7:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || restart) begin
      state_q <= `TXE_LFSR_SEED;
    end else if (advance) begin
      state_q <= state_d;
    end
  end

endmodule // txenc_lfsr

// ===== core/txenc_tx_channel.sv
`timescale 1ns/100ps
`include "txenc_consts.svh"

module txenc_tx_channel (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     cfgWrite,
  input  wire txenc_pkg::txenc_cfg_type cfgIn,
  input  wire logic [7:0]               txCharBits,
  input  wire logic [1:0]               txCharCtrl,
  input  wire logic                     txPhaseError,
  input  wire logic [1:0]               speedRangeSelect,
  output logic [9:0]                    txShiftChar_q,
  output logic                          driverStatic_q,
  output logic                          runDispPos_q,
  output logic [4:0]                    bitClockMult_q,
  output logic [1:0]                    speedBand_q,
  output logic                          speedReserved_q,
  output logic                          selftestActive_q,
  output logic                          wordSyncBusy_q
);
  import txenc_pkg::*;

  txenc_cfg_type  cfg_q;
  txenc_bist_type bist_q;
  txenc_bist_type bist_d;
  logic [3:0]     syncCnt_q;
  logic [3:0]     syncCnt_d;
  logic [1:0]     spdMeta_q;
  logic [1:0]     spdSync_q;
  txenc_char_type encIn;
  txenc_char_type lfsrChar;
  logic [9:0]     encCode;
  logic           encRdPos;
  logic           useEnc;
  logic           lfsrAdvance;
  logic           lfsrRestart;
  logic           lfsrPassLast;
  logic           normalPath;
  logic           encUsed_q;

  // Configuration latches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q.encoderEnableLatch  <= `TXE_RST_ENC_EN;
      cfg_q.txSelftestLatch     <= `TXE_RST_SELFTEST;
      cfg_q.refRateSelect       <= `TXE_RST_RATE;
      cfg_q.localLoopbackEnable <= `TXE_RST_LOOPBACK;
      cfg_q.rxRefClockMode      <= `TXE_RST_RXREF;
    end else if (cfgWrite) begin
      cfg_q <= cfgIn;
    end
  end

  assign normalPath = !txPhaseError && (bist_q == BIST_OFF);

  // Character selection
  always_comb begin
    encIn       = '{viol: 1'h0, isK: 1'h0, code: txCharBits};
    useEnc      = 1'h1;
    lfsrAdvance = 1'h0;
    lfsrRestart = 1'h0;
    syncCnt_d   = syncCnt_q;
    bist_d      = bist_q;
    if (txPhaseError) begin
      encIn.viol = 1'h1;
    end else begin
      case (bist_q)
        BIST_OFF: begin
          if (syncCnt_q != `TXE_SYNC_IDLE) begin
            encIn     = TXENC_FILL_CHAR;
            syncCnt_d = 4'(syncCnt_q + `TXE_SYNC_STEP);
          end else if (!cfg_q.encoderEnableLatch) begin
            useEnc = 1'h0;
          end else begin
            case (txCharCtrl)
              `TXE_CTRL_DATA: begin
                encIn.isK = 1'h0;
              end
              `TXE_CTRL_FILL: begin
                encIn = TXENC_FILL_CHAR;
              end
              `TXE_CTRL_SPECIAL: begin
                encIn = txenc_map_special(txCharBits);
              end
              default: begin
                encIn     = TXENC_FILL_CHAR;
                syncCnt_d = `TXE_SYNC_FIRST;
              end
            endcase
          end
          if (cfg_q.txSelftestLatch && (syncCnt_d == `TXE_SYNC_IDLE)) begin
            bist_d      = cfg_q.rxRefClockMode ? BIST_SYNC : BIST_RUN;
            lfsrRestart = 1'h1;
          end
        end
        BIST_SYNC: begin
          encIn     = TXENC_FILL_CHAR;
          syncCnt_d = 4'(syncCnt_q + `TXE_SYNC_STEP);
          if (syncCnt_q == `TXE_SYNC_LAST) begin
            bist_d = BIST_RUN;
          end
        end
        BIST_RUN: begin
          encIn       = lfsrChar;
          lfsrAdvance = 1'h1;
          if (lfsrPassLast && cfg_q.rxRefClockMode) begin
            bist_d = BIST_SYNC;
          end
        end
        default: begin
          bist_d = BIST_OFF;
        end
      endcase
    end
    if (!cfg_q.txSelftestLatch && (bist_q != BIST_OFF)) begin
      bist_d    = BIST_OFF;
      syncCnt_d = `TXE_SYNC_IDLE;
    end
  end

  txenc_encoder u_encoder (
    .charIn   (encIn),
    .rdPosIn  (runDispPos_q),
    .codeOut  (encCode),
    .rdPosOut (encRdPos)
  );

  txenc_lfsr u_lfsr (
    .core_clk    (core_clk),
    .rst         (rst),
    .restart     (lfsrRestart),
    .advance     (lfsrAdvance),
    .patternChar (lfsrChar),
    .passLast    (lfsrPassLast)
  );

  // Self-test state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bist_q           <= BIST_OFF;
      selftestActive_q <= 1'h0;
    end else begin
      bist_q           <= bist_d;
      selftestActive_q <= (bist_d != BIST_OFF);
    end
  end

  // Word sync counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncCnt_q      <= `TXE_SYNC_IDLE;
      wordSyncBusy_q <= 1'h0;
    end else begin
      syncCnt_q      <= syncCnt_d;
      wordSyncBusy_q <= (syncCnt_d != `TXE_SYNC_IDLE);
    end
  end

  // Character to shifter, code bit a in bit 0 leaves first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txShiftChar_q  <= `TXE_STATIC_ONE;
      driverStatic_q <= 1'h0;
      encUsed_q      <= 1'h0;
    end else begin
      driverStatic_q <= cfg_q.localLoopbackEnable;
      encUsed_q      <= !cfg_q.localLoopbackEnable && useEnc && !encIn.viol;
      if (cfg_q.localLoopbackEnable) begin
        txShiftChar_q <= `TXE_STATIC_ONE;
      end else if (useEnc) begin
        txShiftChar_q <= encCode;
      end else begin
        txShiftChar_q <= {txCharCtrl, txCharBits};
      end
    end
  end

  // Running disparity
  always_ff @(posedge core_clk) begin
    if (rst) begin
      runDispPos_q <= 1'h0;
    end else if (useEnc) begin
      runDispPos_q <= encRdPos;
    end
  end

  // Speed range pin synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      spdMeta_q <= `TXE_SPD_LOW;
      spdSync_q <= `TXE_SPD_LOW;
    end else begin
      spdMeta_q <= speedRangeSelect;
      spdSync_q <= spdMeta_q;
    end
  end

  // Clock multiplier and band
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bitClockMult_q  <= `TXE_MULT_FULL;
      speedBand_q     <= `TXE_SPD_LOW;
      speedReserved_q <= 1'h0;
    end else begin
      bitClockMult_q <= cfg_q.refRateSelect ? `TXE_MULT_HALF : `TXE_MULT_FULL;
      speedBand_q     <= (spdSync_q == `TXE_SPD_HIGH) ? `TXE_SPD_HIGH :
                         (spdSync_q == `TXE_SPD_LOW) ? `TXE_SPD_LOW :
                         `TXE_SPD_MID;
      speedReserved_q <= (spdSync_q == `TXE_SPD_LOW) && cfg_q.refRateSelect;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_syncStart;
    normalPath && (syncCnt_q == `TXE_SYNC_IDLE) &&
    cfg_q.encoderEnableLatch && (txCharCtrl == `TXE_CTRL_SYNC);
  endsequence

  sequence s_syncHold;
    (syncCnt_q != `TXE_SYNC_IDLE)[*8] ##1 (syncCnt_q != `TXE_SYNC_IDLE)[*7];
  endsequence

  property p_syncLength;
    s_syncStart |=> s_syncHold ##1 (syncCnt_q == `TXE_SYNC_IDLE);
  endproperty
  a_syncLength: assert property (p_syncLength)
    else $error("word sync length is not sixteen");

  property p_syncChars;
    normalPath && (syncCnt_q != `TXE_SYNC_IDLE) |=>
      (txShiftChar_q == `TXE_K285_NEG) || (txShiftChar_q == `TXE_K285_POS) ||
      driverStatic_q;
  endproperty
  a_syncChars: assert property (p_syncChars)
    else $error("word sync character is not fill");

  property p_syncRestart;
    (normalPath && (syncCnt_q == `TXE_SYNC_LAST)) ##1 s_syncStart |=>
      (syncCnt_q == `TXE_SYNC_FIRST);
  endproperty
  a_syncRestart: assert property (p_syncRestart)
    else $error("word sync did not restart");

  property p_bypass;
    normalPath && (syncCnt_q == `TXE_SYNC_IDLE) &&
    !cfg_q.encoderEnableLatch && !cfg_q.localLoopbackEnable |=>
      txShiftChar_q == $past({txCharCtrl, txCharBits});
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass character altered");

  property p_loopback;
    cfg_q.localLoopbackEnable |=>
      driverStatic_q && (txShiftChar_q == `TXE_STATIC_ONE);
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback output not static one");

  property p_phaseError;
    txPhaseError && !cfg_q.localLoopbackEnable |=>
      (txShiftChar_q == `TXE_VIOL_NEG) || (txShiftChar_q == `TXE_VIOL_POS);
  endproperty
  a_phaseError: assert property (p_phaseError)
    else $error("phase error without violation character");

  property p_bistReset;
    @(posedge core_clk) disable iff (1'b0)
      rst |=> !cfg_q.txSelftestLatch && (bist_q == BIST_OFF);
  endproperty
  a_bistReset: assert property (p_bistReset)
    else $error("self-test enabled after reset");

  property p_multiplier;
    1'b1 |=> bitClockMult_q ==
      ($past(cfg_q.refRateSelect) ? `TXE_MULT_HALF : `TXE_MULT_FULL);
  endproperty
  a_multiplier: assert property (p_multiplier)
    else $error("clock multiplier does not follow rate");

  property p_balance;
    encUsed_q |-> ($countones(txShiftChar_q) inside {4, 5, 6});
  endproperty
  a_balance: assert property (p_balance)
    else $error("encoded character out of disparity bounds");

  property p_passSync;
    (bist_q == BIST_RUN) && lfsrPassLast && cfg_q.rxRefClockMode &&
    cfg_q.txSelftestLatch && !txPhaseError |=> (bist_q == BIST_SYNC)[*8];
  endproperty
  a_passSync: assert property (p_passSync)
    else $error("pattern pass not preceded by word sync");

endmodule // txenc_tx_channel

// ===== verif/txenc_host_model.sv
`timescale 1ns/100ps

module txenc_host_model (
  output logic [7:0] txCharBits,
  output logic [1:0] txCharCtrl,
  output logic [1:0] speedRangeSelect
);
  initial begin
    txCharBits       = 8'h00;
    txCharCtrl       = 2'h0;
    speedRangeSelect = 2'h0;
  end

  // Band pin, reserved only on command
  task automatic drive(input logic [1:0] ctrl, input logic [7:0] data,
                       input logic [1:0] band);
    txCharCtrl       <= ctrl;
    txCharBits       <= data;
    speedRangeSelect <= band;
  endtask
endmodule // txenc_host_model

// ===== verif/tx_channel_8b10b_encoder_tb_top.sv
`timescale 1ns/100ps
`include "txenc_consts.svh"

module tx_channel_8b10b_encoder_tb_top;
  import txenc_pkg::*;
  logic                   core_clk;
  logic                   rst;
  logic                   cfgWrite;
  txenc_cfg_type          cfgIn;
  logic [7:0]             txCharBits;
  logic [1:0]             txCharCtrl;
  logic                   txPhaseError;
  logic [1:0]             speedRangeSelect;
  logic [9:0]             txShiftChar_q;
  logic                   driverStatic_q;
  logic                   runDispPos_q;
  logic [4:0]             bitClockMult_q;
  logic [1:0]             speedBand_q;
  logic                   speedReserved_q;
  logic                   selftestActive_q;
  logic                   wordSyncBusy_q;
  int                     bad_count;
  int                     n_tests;
  int                     firstRun;
  logic                   rdPos;
  logic                   pendValid;
  logic [9:0]             pendChar;
  logic                   phaseErr;
  logic [1:0]             bandSel;
  logic [7:0]             cb;
  logic [1:0]             cc;
  logic [9:0]             trace [0:559];

  txenc_tx_channel u_dut (
    .core_clk(core_clk), .rst(rst), .cfgWrite(cfgWrite), .cfgIn(cfgIn),
    .txCharBits(txCharBits), .txCharCtrl(txCharCtrl),
    .txPhaseError(txPhaseError), .speedRangeSelect(speedRangeSelect),
    .txShiftChar_q(txShiftChar_q), .driverStatic_q(driverStatic_q),
    .runDispPos_q(runDispPos_q), .bitClockMult_q(bitClockMult_q),
    .speedBand_q(speedBand_q), .speedReserved_q(speedReserved_q),
    .selftestActive_q(selftestActive_q), .wordSyncBusy_q(wordSyncBusy_q));

  txenc_host_model u_host (
    .txCharBits(txCharBits), .txCharCtrl(txCharCtrl),
    .speedRangeSelect(speedRangeSelect));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmpChar(input string nm, input logic [9:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmpFlag(input string nm, input logic e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmpField(input string nm, input logic [4:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [9:0] fillCode();
    fillCode = rdPos ? `TXE_K285_POS : `TXE_K285_NEG;
    rdPos = ~rdPos;
  endfunction

  function automatic logic [9:0] violCode();
    violCode = rdPos ? `TXE_VIOL_POS : `TXE_VIOL_NEG;
  endfunction

  function automatic logic isK(input logic [9:0] v);
    isK = (v === `TXE_K285_NEG) || (v === `TXE_K285_POS);
  endfunction

  function automatic txenc_cfg_type mk(input logic e, st, rt, lb, rx);
    mk = '{encoderEnableLatch: e, txSelftestLatch: st, refRateSelect: rt,
           localLoopbackEnable: lb, rxRefClockMode: rx};
  endfunction

  // Drive one character; check the one driven a cycle earlier
  task automatic chr(input logic [1:0] ctrl, input logic [7:0] data,
                     input logic [9:0] expV);
    @(posedge core_clk);
    u_host.drive(ctrl, data, bandSel);
    txPhaseError <= phaseErr;
    #1;
    if (pendValid) cmpChar("txShiftChar_q", pendChar, txShiftChar_q);
    pendValid = 1'b1;
    pendChar  = expV;
  endtask

  // Config write with a disparity neutral character held
  task automatic cfgSet(input txenc_cfg_type v);
    @(posedge core_clk);
    cfgWrite <= 1'b1;
    cfgIn    <= v;
    u_host.drive(`TXE_CTRL_DATA, 8'hB5, bandSel);
    #1;
    if (pendValid) cmpChar("txShiftChar_q", pendChar, txShiftChar_q);
    pendValid = 1'b0;
    @(posedge core_clk);
    cfgWrite <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    results();
  end

  initial begin
    void'($urandom(32'hAFF58A70));
    rst = 1'b1; cfgWrite = 1'b0; cfgIn = mk(1, 0, 0, 0, 0);
    txPhaseError = 1'b0; phaseErr = 1'b0; bandSel = 2'h0;
    bad_count = 0; n_tests = 0; rdPos = 1'b0; pendValid = 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    cmpFlag("selftestActive_q", 1'b0, selftestActive_q);
    cmpField("bitClockMult_q", `TXE_MULT_FULL, bitClockMult_q);
    // Encoded characters and special tables
    chr(`TXE_CTRL_FILL, 8'h00, fillCode());
    chr(`TXE_CTRL_FILL, 8'($urandom), fillCode());
    chr(`TXE_CTRL_DATA, 8'hB5, 10'h155);
    chr(`TXE_CTRL_SPECIAL, 8'hBC, fillCode());
    chr(`TXE_CTRL_SPECIAL, 8'h05, fillCode());
    chr(`TXE_CTRL_SPECIAL, 8'h55, violCode());
    // Word sync, then a restart at its end
    repeat (2) begin
      chr(`TXE_CTRL_SYNC, 8'($urandom), fillCode());
      for (int i = 0; i < 15; i++) begin
        chr(2'($urandom), 8'($urandom), fillCode());
        cmpFlag("wordSyncBusy_q", 1'b1, wordSyncBusy_q);
      end
    end
    chr(`TXE_CTRL_DATA, 8'hB5, 10'h155);
    cmpFlag("wordSyncBusy_q", 1'b0, wordSyncBusy_q);
    chr(`TXE_CTRL_DATA, 8'hB5, 10'h155);
    // Bypass, random and corner bit positions
    cfgSet(mk(0, 0, 0, 0, 0));
    repeat (40) begin
      cb = 8'($urandom);
      cc = 2'($urandom);
      chr(cc, cb, {cc, cb});
    end
    chr(2'h3, 8'h00, 10'h300);
    chr(2'h0, 8'h01, 10'h001);
    chr(2'h0, 8'h20, 10'h020);
    // Phase error overrides everything except loopback
    cfgSet(mk(1, 0, 0, 0, 0));
    phaseErr = 1'b1;
    repeat (6) chr(2'($urandom), 8'($urandom), violCode());
    phaseErr = 1'b0;
    chr(`TXE_CTRL_FILL, 8'h00, fillCode());
    // Loopback forces static one
    cfgSet(mk(1, 0, 0, 1, 0));
    chr(`TXE_CTRL_DATA, 8'hB5, `TXE_STATIC_ONE);
    cmpFlag("runDispPos_q", rdPos, runDispPos_q);
    chr(`TXE_CTRL_DATA, 8'hB5, `TXE_STATIC_ONE);
    cmpFlag("driverStatic_q", 1'b1, driverStatic_q);
    cfgSet(mk(1, 0, 0, 0, 0));
    chr(`TXE_CTRL_FILL, 8'h00, fillCode());
    cmpFlag("driverStatic_q", 1'b0, driverStatic_q);
    // Rate and band, including the reserved pairing
    for (int r = 0; r < 2; r++) begin
      cfgSet(mk(1, 0, r[0], 0, 0));
      for (int s = 0; s < 4; s++) begin
        bandSel = 2'(s);
        repeat (4) chr(`TXE_CTRL_DATA, 8'hB5, 10'h155);
        cmpField("bitClockMult_q", (r == 1) ? `TXE_MULT_HALF
                 : `TXE_MULT_FULL, bitClockMult_q);
        cmpField("speedBand_q", {3'h0, (s == 3) ? `TXE_SPD_MID
                 : 2'(s)}, {3'h0, speedBand_q});
        cmpFlag("speedReserved_q", (s == 0 && r == 1),
                speedReserved_q);
      end
    end
    // Self-test with sync before each pass, host inputs random
    cfgSet(mk(1, 1, 0, 0, 1));
    firstRun = -1;
    for (int i = 0; i < 560; i++) begin
      @(posedge core_clk);
      u_host.drive(2'($urandom), 8'($urandom), bandSel);
      #1;
      trace[i] = txShiftChar_q;
      if (i == 0) begin
        cmpFlag("selftestActive_q", 1'b1, selftestActive_q);
      end
      if (i > 0 && firstRun < 0 && !isK(trace[i])) firstRun = i;
    end
    // Entry character, sixteen sync, then a full pass
    for (int i = 1; i <= 16; i++) begin
      cmpFlag("selftest sync char", 1'b1, isK(trace[i]));
    end
    cmpFlag("selftest pass start", 1'b1, firstRun == 17);
    cmpFlag("selftest pass last", 1'b0, isK(trace[527]));
    for (int i = 0; i < 16; i++) begin
      cmpFlag("selftest pass end", 1'b1,
              isK(trace[528 + i]));
    end
    cmpFlag("selftest next pass", 1'b0, isK(trace[544]));
    // Reset in mid self-test
    @(posedge core_clk);
    rst <= 1'b1;
    u_host.drive(`TXE_CTRL_DATA, 8'hB5, bandSel);
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    cmpFlag("selftestActive_q", 1'b0, selftestActive_q);
    pendValid = 1'b0;
    rdPos = 1'b0;
    chr(`TXE_CTRL_FILL, 8'h00, fillCode());
    chr(`TXE_CTRL_DATA, 8'hB5, 10'h155);
    chr(`TXE_CTRL_DATA, 8'hB5, 10'h155);
    results();
  end
endmodule // tx_channel_8b10b_encoder_tb_top
